/* File: smgc_pkg.sv */
// Purpose: constants for the protected system configuration block
// Assumes: 8-bit special function register port, 100 MHz system clock
// Notes: offsets are local choices; the identity value is arbitrary
package smgc_pkg;
    localparam logic [7:0] addr_system_setup = 8'hb1;
    localparam logic [7:0] addr_part_identifier = 8'ha1;
    localparam logic [7:0] addr_protected_write_unlock = 8'ha2;
    localparam logic [7:0] unlock_first = 8'h55;
    localparam logic [7:0] unlock_second = 8'haa;
    localparam logic [7:0] unlock_reset = 8'h00;
    localparam logic [7:0] part_identifier_value = 8'h3c; // arbitrary value
    localparam logic [1:0] setup_top_bits = 2'h1; // arbitrary value
    localparam int bit_loader = 5;
    localparam int bit_restart = 4;
    localparam int bit_prog_we = 3;
    localparam int bit_data_we = 2;
    localparam int bit_reg_off = 1;
    localparam int bit_wdog = 0;
    localparam logic [3:0] setup_rw_reset = 4'h0;
    // window length in system clocks, inside the 13..23 range
    localparam int window_cycles = 16;
    localparam logic [4:0] window_count = 5'(window_cycles - 1);
    // bounds that any expired window must respect
    localparam int window_min = 13;
    localparam int window_max = 23;
    typedef enum logic [1:0] {smgc_locked, smgc_armed, smgc_open} smgc_state_type;
endpackage

/* File: smgc_top.sv */
// Purpose: safe mode gate, system setup and part identifier registers
// Assumes: power_on_reset is the power-on reset, reset is any device reset
// Notes: read data appear the cycle after the read strobe only
`timescale 1ns/1ps
module smgc_top (
    // clock and resets
    input wire logic clock,
    input wire logic reset,
    input wire logic power_on_reset,
    // register port
    input wire logic [7:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [7:0] read_data,
    // control outputs
    output logic soft_restart_pulse,
    output logic safe_mode_open,
    output logic program_flash_write_enable,
    output logic data_flash_write_enable,
    output logic regulator_disable,
    output logic watchdog_reset_enable
);
    smgc_pkg::smgc_state_type state_reg;
    logic [4:0] count_reg;
    logic [3:0] setup_reg;
    logic loader_reg;
    logic restart_reg;
    logic unlock_wr;
    logic setup_wr;

    assign unlock_wr = write_strobe && address == smgc_pkg::addr_protected_write_unlock;
    assign setup_wr = write_strobe && address == smgc_pkg::addr_system_setup;

    // unlock sequence and window timer
    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= smgc_pkg::smgc_locked;
            count_reg <= 5'h00;
        end else begin
            case (state_reg)
                smgc_pkg::smgc_locked: begin
                    if (unlock_wr && write_data == smgc_pkg::unlock_first) begin
                        state_reg <= smgc_pkg::smgc_armed;
                    end
                end
                smgc_pkg::smgc_armed: begin
                    // only the very next unlock write counts; other writes in between are ignored
                    if (unlock_wr) begin
                        if (write_data == smgc_pkg::unlock_second) begin
                            state_reg <= smgc_pkg::smgc_open;
                            count_reg <= smgc_pkg::window_count;
                        end else if (write_data == smgc_pkg::unlock_first) begin
                            state_reg <= smgc_pkg::smgc_armed;
                        end else begin
                            state_reg <= smgc_pkg::smgc_locked;
                        end
                    end
                end
                smgc_pkg::smgc_open: begin
                    if (unlock_wr) begin
                        state_reg <= smgc_pkg::smgc_locked;
                    end else if (count_reg == 5'h00) begin
                        state_reg <= smgc_pkg::smgc_locked;
                    end else begin
                        count_reg <= count_reg - 5'h01;
                    end
                end
                default: state_reg <= smgc_pkg::smgc_locked;
            endcase
        end
    end

    assign safe_mode_open = state_reg == smgc_pkg::smgc_open;

    // protected writable bits; any reset clears them
    always_ff @(posedge clock) begin
        if (reset) begin
            setup_reg <= smgc_pkg::setup_rw_reset;
        end else if (setup_wr && safe_mode_open) begin
            setup_reg <= write_data[3:0];
        end
    end

    // restart trigger: one-cycle pulse, self-clearing
    always_ff @(posedge clock) begin
        if (reset) begin
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= setup_wr && safe_mode_open && write_data[smgc_pkg::bit_restart];
        end
    end

    // loader flag: only power-on sets it, so it tells soft restarts apart
    always_ff @(posedge clock) begin
        if (power_on_reset) begin
            loader_reg <= 1'b1;
        end else if (restart_reg) begin
            loader_reg <= 1'b0;
        end
    end

    assign soft_restart_pulse = restart_reg;
    assign program_flash_write_enable = setup_reg[smgc_pkg::bit_prog_we];
    assign data_flash_write_enable = setup_reg[smgc_pkg::bit_prog_we] || setup_reg[smgc_pkg::bit_data_we];
    assign regulator_disable = setup_reg[smgc_pkg::bit_reg_off];
    assign watchdog_reset_enable = setup_reg[smgc_pkg::bit_wdog];

    // read port; unlock register is write-only and reads zero
    always_ff @(posedge clock) begin
        if (reset) begin
            read_data <= 8'h00;
        end else if (read_strobe) begin
            case (address)
                smgc_pkg::addr_system_setup:
                    read_data <= {smgc_pkg::setup_top_bits, loader_reg, 1'b0, setup_reg};
                smgc_pkg::addr_part_identifier: read_data <= smgc_pkg::part_identifier_value;
                default: read_data <= 8'h00;
            endcase
        end else begin
            read_data <= 8'h00;
        end
    end

    // checks
    // helper: length of the current open run, read only by the checks below
    logic [4:0] open_run_reg;
    always_ff @(posedge clock) begin
        if (reset) begin
            open_run_reg <= 5'h00;
        end else if (safe_mode_open) begin
            open_run_reg <= open_run_reg + 5'h01;
        end else begin
            open_run_reg <= 5'h00;
        end
    end

    // entry pair: the second byte right after 55h opens the window
    // armed state stands for the 55h half already seen
    chk_entry_opens: assert property (
        @(posedge clock) disable iff (reset)
        $past(state_reg) == smgc_pkg::smgc_armed && $past(unlock_wr)
        && $past(write_data) == smgc_pkg::unlock_second
        |-> safe_mode_open)
        else $error("window did not open");

    // a lone 55h only arms the gate, it never opens it
    // opening on the first byte would make the pair pointless
    chk_first_arms: assert property (
        @(posedge clock) disable iff (reset)
        state_reg == smgc_pkg::smgc_locked && unlock_wr && write_data == smgc_pkg::unlock_first
        |=> state_reg == smgc_pkg::smgc_armed && !safe_mode_open)
        else $error("first byte not armed");

    // other registers may be touched between the two bytes
    // so the armed state waits for the next unlock write
    chk_armed_wait: assert property (
        @(posedge clock) disable iff (reset)
        state_reg == smgc_pkg::smgc_armed && !unlock_wr
        |=> state_reg == smgc_pkg::smgc_armed)
        else $error("armed state lost");

    // a repeated 55h keeps the gate armed
    chk_armed_repeat: assert property (
        @(posedge clock) disable iff (reset)
        state_reg == smgc_pkg::smgc_armed && unlock_wr && write_data == smgc_pkg::unlock_first
        |=> state_reg == smgc_pkg::smgc_armed)
        else $error("repeat first byte dropped");

    // from locked there is no direct path to open
    chk_no_skip: assert property (
        @(posedge clock) disable iff (reset)
        state_reg == smgc_pkg::smgc_locked
        |=> !safe_mode_open)
        else $error("opened without the pair");

    // a wrong second byte must not open the window
    // the whole pair has to be written again, unless the wrong byte is 55h, which keeps the gate armed
    chk_bad_second: assert property (
        @(posedge clock) disable iff (reset)
        state_reg == smgc_pkg::smgc_armed && unlock_wr && write_data != smgc_pkg::unlock_second
        |=> !safe_mode_open)
        else $error("wrong byte opened window");

    // every window starts from the full count
    // a stale count would shorten the window silently
    chk_window_load: assert property (
        @(posedge clock) disable iff (reset)
        $rose(safe_mode_open)
        |-> count_reg == smgc_pkg::window_count)
        else $error("window count not loaded");

    // nothing but the count, an unlock write or a reset may shut an open window
    // software relies on the full window for its protected writes
    chk_window_length: assert property (
        @(posedge clock) disable iff (reset)
        safe_mode_open && !unlock_wr && count_reg != 5'h00
        |=> safe_mode_open)
        else $error("window too short");

    // the count never exceeds its load value while open
    chk_count_range: assert property (
        @(posedge clock) disable iff (reset)
        safe_mode_open
        |-> count_reg <= smgc_pkg::window_count)
        else $error("window count out of range");

    // an expired window lasted within the allowed 13 to 23 clocks
    // unlock writes and resets cut it short, so those runs are left out
    chk_run_length: assert property (
        @(posedge clock) disable iff (reset)
        $fell(safe_mode_open) && !$past(unlock_wr) && !$past(reset)
        |-> open_run_reg >= smgc_pkg::window_min && open_run_reg <= smgc_pkg::window_max)
        else $error("window length outside range");

    // the window shuts by itself once the count runs out
    // no software action is needed to close it
    chk_window_expires: assert property (
        @(posedge clock) disable iff (reset)
        $rose(safe_mode_open)
        |-> ##[1:23] !safe_mode_open)
        else $error("window never closed");

    // last count step: the gate locks on the next edge
    chk_expire_close: assert property (
        @(posedge clock) disable iff (reset)
        safe_mode_open && !unlock_wr && count_reg == 5'h00
        |=> state_reg == smgc_pkg::smgc_locked)
        else $error("window outlived its count");

    // any unlock write while open ends the window at once
    // the written value does not matter here
    chk_early_close: assert property (
        @(posedge clock) disable iff (reset)
        safe_mode_open && unlock_wr
        |=> !safe_mode_open)
        else $error("unlock write did not close");

    // closed gate: a setup write is dropped without trace
    // no partial update may leak into the flash or power controls
    chk_locked_write: assert property (
        @(posedge clock) disable iff (reset)
        setup_wr && !safe_mode_open
        |=> $stable(setup_reg))
        else $error("protected write leaked");

    // protected bits move only on a setup write
    chk_setup_hold: assert property (
        @(posedge clock) disable iff (reset)
        !setup_wr
        |=> $stable(setup_reg))
        else $error("setup bits changed unasked");

    // open gate: the writable bits take the written value
    // the restart bit is not stored, it only fires the pulse
    chk_open_write: assert property (
        @(posedge clock) disable iff (reset)
        setup_wr && safe_mode_open
        |=> setup_reg == $past(write_data[3:0]))
        else $error("setup not written");

    // flash gates follow the written enables: bit 3 opens both stores, bit 2 data alone
    chk_flash_gates: assert property (
        @(posedge clock) disable iff (reset)
        setup_wr && safe_mode_open
        |=> program_flash_write_enable == $past(write_data[smgc_pkg::bit_prog_we])
            && data_flash_write_enable == ($past(write_data[smgc_pkg::bit_prog_we])
            || $past(write_data[smgc_pkg::bit_data_we])))
        else $error("flash gates wrong");

    // regulator and watchdog controls follow their written bits
    chk_power_gates: assert property (
        @(posedge clock) disable iff (reset)
        setup_wr && safe_mode_open
        |=> regulator_disable == $past(write_data[smgc_pkg::bit_reg_off])
            && watchdog_reset_enable == $past(write_data[smgc_pkg::bit_wdog]))
        else $error("power controls wrong");

    // any reset returns the writable bits and the gate to their idle values
    // so flash stays protected and the regulator runs after every reset
    chk_reset_values: assert property (
        @(posedge clock)
        reset
        |=> setup_reg == smgc_pkg::setup_rw_reset && state_reg == smgc_pkg::smgc_locked && !soft_restart_pulse)
        else $error("reset values wrong");

    // the restart request is one clock wide and clears itself;
    // the system loops it onto reset, so reset cannot gate this check
    chk_restart_pulse: assert property (
        @(posedge clock) disable iff (power_on_reset)
        soft_restart_pulse
        |=> !soft_restart_pulse)
        else $error("restart not self clearing");

    // a restart only follows a safe-mode setup write
    chk_restart_cause: assert property (
        @(posedge clock) disable iff (power_on_reset)
        soft_restart_pulse
        |-> $past(setup_wr) && $past(safe_mode_open))
        else $error("restart without open write");

    // power-on alone sets the loader flag
    chk_loader_set: assert property (
        @(posedge clock)
        power_on_reset
        |=> loader_reg)
        else $error("loader flag not set");

    // a soft restart clears the loader flag, marking the restart
    chk_loader_clear: assert property (
        @(posedge clock) disable iff (power_on_reset)
        soft_restart_pulse
        |=> !loader_reg)
        else $error("loader flag kept");

    // setup read shows the loader flag, a zero trigger bit and the writable bits
    chk_setup_read: assert property (
        @(posedge clock) disable iff (reset)
        read_strobe && address == smgc_pkg::addr_system_setup
        |=> read_data[smgc_pkg::bit_loader] == $past(loader_reg) && !read_data[smgc_pkg::bit_restart]
            && read_data[3:0] == $past(setup_reg))
        else $error("setup read wrong");

    // the identifier reads the same fixed code every time
    // earlier writes to it must leave no mark
    chk_ident_read: assert property (
        @(posedge clock) disable iff (reset)
        read_strobe && address == smgc_pkg::addr_part_identifier
        |=> read_data == smgc_pkg::part_identifier_value)
        else $error("bad identifier");

    // the unlock register is write-only and reads back as zero
    chk_unlock_read: assert property (
        @(posedge clock) disable iff (reset)
        read_strobe && address == smgc_pkg::addr_protected_write_unlock
        |=> read_data == smgc_pkg::unlock_reset)
        else $error("unlock register readable");

    // main scenarios
    cov_open: cover property (@(posedge clock) $rose(safe_mode_open));
    cov_expire: cover property (@(posedge clock) safe_mode_open && count_reg == 5'h00 && !unlock_wr);
    cov_early_close: cover property (@(posedge clock) safe_mode_open && unlock_wr);
    cov_restart: cover property (@(posedge clock) soft_restart_pulse);
    cov_flash_we: cover property (@(posedge clock) $rose(program_flash_write_enable));
endmodule

/* File: smgc_tb.sv */
// Purpose: self-checking bench for the safe mode gate and setup registers
// Assumes: soft restart pulse is looped back onto reset, as the system would do
// Notes: expectations come from a small model kept in the bench, never from outputs
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
    localparam logic [7:0] a_set = smgc_pkg::addr_system_setup;
    localparam logic [7:0] a_id = smgc_pkg::addr_part_identifier;
    localparam logic [7:0] a_unl = smgc_pkg::addr_protected_write_unlock;
    logic clock = 1'b0;
    logic bench_reset = 1'b1;
    logic power_on_reset = 1'b1;
    logic [7:0] address = 8'h00;
    logic [7:0] write_data = 8'h00;
    logic write_strobe = 1'b0;
    logic read_strobe = 1'b0;
    logic [7:0] read_data;
    logic soft_restart_pulse, safe_mode_open, pf_we, df_we, reg_off, wd_en;
    logic [7:0] d;
    logic [3:0] m_bits = 4'h0;
    logic m_loader = 1'b1;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    int seed = 32'hd712a71e;
    // restart pulse feeds the device reset, a hazard the system must close
    wire logic reset = bench_reset | soft_restart_pulse;
    smgc_top i_smgc_top (.clock(clock), .reset(reset), .power_on_reset(power_on_reset), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .soft_restart_pulse(soft_restart_pulse), .safe_mode_open(safe_mode_open),
        .program_flash_write_enable(pf_we), .data_flash_write_enable(df_we),
        .regulator_disable(reg_off), .watchdog_reset_enable(wd_en));
    // 100 MHz clock
    initial forever #5 clock = ~clock;
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // hang guard, well under two hundred cycles are expected
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            close_out;
        end
    end
    function automatic logic [7:0] exp_setup;
        return {smgc_pkg::setup_top_bits, m_loader, 1'b0, m_bits};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        address <= a;
        write_data <= v;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        `CHK(read_data, e)
    endtask
    task automatic outs;
        #1;
        `CHK({pf_we, df_we, reg_off, wd_en}, {m_bits[3], m_bits[3] | m_bits[2], m_bits[1], m_bits[0]})
    endtask
    task automatic unlock;
        wr(a_unl, 8'h55);
        wr(a_unl, 8'haa);
    endtask
    // main sequence
    initial begin
        repeat (3) @(posedge clock);
        bench_reset <= 1'b0;
        power_on_reset <= 1'b0;
        rd(a_id, smgc_pkg::part_identifier_value);
        wr(a_id, 8'($random(seed)));
        rd(a_id, smgc_pkg::part_identifier_value);
        rd(a_unl, 8'h00);
        rd(8'h00, 8'h00);
        rd(a_set, exp_setup());
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            wr(a_set, 8'($random(seed)));
            rd(a_set, exp_setup());
        end
        outs;
        wr(a_unl, 8'h55);
        wr(a_unl, 8'h5a);
        wr(a_set, 8'h0f);
        rd(a_set, exp_setup());
        $display("test closed writes done");
        unlock;
        #1;
        n = 0;
        while (safe_mode_open === 1'b1 && n < 40) begin
            n++;
            @(posedge clock);
            #1;
        end
        `CHK(n, smgc_pkg::window_cycles)
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed)) & 8'hef;
            unlock;
            wr(a_set, d);
            m_bits = d[3:0];
            outs;
            rd(a_set, exp_setup());
            wr(a_unl, 8'($random(seed)));
            #1;
            `CHK(safe_mode_open, 1'b0)
        end
        unlock;
        wr(a_unl, 8'($random(seed)));
        wr(a_set, 8'h00);
        rd(a_set, exp_setup());
        $display("test window done");
        unlock;
        wr(a_set, 8'h10);
        n = 0;
        repeat (4) begin
            #1;
            if (soft_restart_pulse === 1'b1) n++;
            @(posedge clock);
        end
        `CHK(n, 1)
        m_loader = 1'b0;
        m_bits = 4'h0;
        outs;
        rd(a_set, exp_setup());
        $display("test soft restart done");
        close_out;
    end
endmodule
